//--- src/powerup_seq_pkg.sv
// Purpose: Shared constants for the power-up and reset sequencer
// Assumes: 50 MHz system clock
// Notes: Settling counts per data rate are given in master-clock periods
package powerup_seq_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   // Oscillator start-up least wait, in microseconds
   localparam int unsigned OSC_START_US = 20;
   localparam int unsigned OSC_START_CYC = (OSC_START_US * (CLK_HZ / 1_000_000));
   // Valid-data wait after reset release, in microseconds (2.2 ms)
   localparam int unsigned STABLE_US = 2200;
   localparam int unsigned STABLE_CYC = (STABLE_US * (CLK_HZ / 1_000_000));
   // Power-up budget, in microseconds
   localparam int unsigned POWERUP_US = 3000;
   localparam int unsigned POWERUP_CYC = (POWERUP_US * (CLK_HZ / 1_000_000));
   // Least reset-after-clock delay, master-clock periods
   localparam int unsigned RESET_AFTER_CLOCK_DELAY = 2;
   // Filter settling at the default rate, master-clock periods
   localparam int unsigned SETTLE_DEFAULT = 2312;
   localparam int unsigned CNT_W = 24;
   localparam logic [2:0] RATE_RST = 3'h4;
   // Settling count for each rate code
   function automatic logic [CNT_W-1:0] settle_count(input logic [2:0] rate);
      logic [CNT_W-1:0] c;
      c = CNT_W'(SETTLE_DEFAULT);
      case (rate)
         3'h0: c = 24'h000128;
         3'h1: c = 24'h000248;
         3'h2: c = 24'h000488;
         3'h3: c = 24'h000908;
         3'h4: c = CNT_W'(SETTLE_DEFAULT);
         3'h5: c = 24'h002408;
         3'h6: c = 24'h004808;
         default: c = CNT_W'(SETTLE_DEFAULT);
      endcase
      return c;
   endfunction
   // Conversion period per rate code, master-clock periods
   function automatic logic [CNT_W-1:0] period_count(input logic [2:0] rate);
      logic [CNT_W-1:0] p;
      p = 24'h000200;
      case (rate)
         3'h0: p = 24'h000020;
         3'h1: p = 24'h000040;
         3'h2: p = 24'h000080;
         3'h3: p = 24'h000100;
         3'h4: p = 24'h000200;
         3'h5: p = 24'h000400;
         3'h6: p = 24'h000800;
         default: p = 24'h000200;
      endcase
      return p;
   endfunction
endpackage

//--- src/sync2.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Single clock domain on the reading side
// Notes: First stage is read by the second stage only
module sync2 #(
   parameter int W = 1
) (
   input wire logic i_clk, // System clock
   input wire logic i_rst_n, // Synchronous reset, active low
   input wire logic [W-1:0] i_d, // Asynchronous input
   output logic [W-1:0] o_q // Synchronised output
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;
   // Two-stage capture
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= i_d;
         q_ff <= meta_ff;
      end
   end
   assign o_q = q_ff;
endmodule

//--- src/adc_powerup_reset_sequencer.sv
// Purpose: Power-up and reset sequencing of a delta-sigma converter front end
// Assumes: Master clock enters as a pin sampled by the 50 MHz i_clk
// Notes: Counts master-clock rising edges; data_ready_n pulses low per result
// Operation
// - Internal oscillator starts no earlier than 20 us after supply is good.
// - Reset rising edge releases filters and starts conversion.
// - First data-ready fall flags settled filter data, 2312 periods at default rate.
// - Data valid only at first data-ready fall after 2.2 ms from reset release.
// - A register write postpones the settling countdown until it completes.
// - A rate change restarts settling with the new rate's count.
// - Settled data available within 3 ms of power when sequence followed.
module adc_powerup_reset_sequencer #(
   parameter int unsigned STABLE_CYCLES = powerup_seq_pkg::STABLE_CYC,
   parameter int unsigned OSC_CYCLES = powerup_seq_pkg::OSC_START_CYC,
   parameter int unsigned POWERUP_CYCLES = powerup_seq_pkg::POWERUP_CYC
) (
   input wire logic i_clk, // 50 MHz system clock
   input wire logic i_rst_n, // Synchronous reset, active low
   input wire logic i_supply_good, // Analog supply above 90% (pin)
   input wire logic i_use_int_osc, // Internal oscillator select (pin)
   input wire logic i_master_clk, // External master clock (pin)
   input wire logic i_reset_pin_n, // Converter reset pin, active low
   input wire logic i_reg_write_busy, // Register write in progress
   input wire logic i_reg_write_done, // Register write completed, pulse
   input wire logic i_rate_write, // Data-rate command completed, pulse
   input wire logic [2:0] i_rate, // New data-rate code
   output logic o_osc_running, // Internal oscillator started
   output logic o_filter_run, // Decimation filters released
   output logic o_data_ready_n, // Data ready, active low
   output logic o_settled, // Filter settled
   output logic o_valid, // Filter and nodes settled; a later restart leaves it set
   output logic o_powerup_late // Settled data missed the 3 ms budget
);
   typedef enum logic [1:0] {S_RESET, S_SETTLE, S_RUN} seq_state_t;

   logic mclk_s;
   logic rstpin_n_s;
   logic supply_s;
   logic intosc_s;
   sync2 #(.W(4)) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_d({i_master_clk, i_reset_pin_n, i_supply_good, i_use_int_osc}),
      .o_q({mclk_s, rstpin_n_s, supply_s, intosc_s})
   );

   seq_state_t state_ff, nxt_state;
   logic mclk_d_ff;
   logic rst_d_ff;
   logic [powerup_seq_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [powerup_seq_pkg::CNT_W-1:0] per_ff, nxt_per;
   logic [2:0] rate_ff;
   logic [31:0] osc_cnt_ff;
   logic [31:0] stable_cnt_ff;
   logic [31:0] pwr_cnt_ff;
   logic osc_ff, run_ff, data_ready_n_n_ff, settled_ff, valid_ff, late_ff;
   logic stable_ff;

   // Edge and tick decode
   wire osc_tick = osc_ff & intosc_s;
   wire mclk_rise = (mclk_s & ~mclk_d_ff & ~intosc_s) | osc_tick;
   wire rst_rise = rstpin_n_s & ~rst_d_ff;
   wire rst_held = ~rstpin_n_s;
   wire hold = i_reg_write_busy;
   wire restart = i_reg_write_done | i_rate_write;
   wire [2:0] new_rate = i_rate_write ? i_rate : rate_ff;
   wire [powerup_seq_pkg::CNT_W-1:0] settle_new = powerup_seq_pkg::settle_count(new_rate);
   wire [powerup_seq_pkg::CNT_W-1:0] period_cur = powerup_seq_pkg::period_count(rate_ff);
   wire cnt_zero = (cnt_ff == '0);
   wire stable_done = (stable_cnt_ff >= STABLE_CYCLES);

   // Sequencer next state
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_per = per_ff;
      case (state_ff)
         S_RESET: begin
            if (rst_rise) begin
               nxt_state = S_SETTLE;
               nxt_cnt = powerup_seq_pkg::settle_count(rate_ff);
            end
         end
         S_SETTLE: begin
            if (restart) begin
               nxt_cnt = settle_new;
            end else if (!hold && mclk_rise) begin
               if (cnt_ff <= 24'h000001) begin
                  nxt_state = S_RUN;
                  nxt_per = period_cur;
               end else begin
                  nxt_cnt = cnt_ff - 24'h000001;
               end
            end
         end
         S_RUN: begin
            if (restart) begin
               nxt_state = S_SETTLE;
               nxt_cnt = settle_new;
            end else if (mclk_rise) begin
               nxt_per = (per_ff <= 24'h000001) ? period_cur : per_ff - 24'h000001;
            end
         end
         default: nxt_state = S_RESET;
      endcase
      if (rst_held) begin
         nxt_state = S_RESET;
      end
   end

   wire result_evt = (state_ff == S_SETTLE && nxt_state == S_RUN)
      | (state_ff == S_RUN && mclk_rise && per_ff <= 24'h000001 && !restart && !rst_held);

   // Sequencer registers
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_ff <= S_RESET;
         cnt_ff <= '0;
         per_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         per_ff <= nxt_per;
      end
   end

   // Edge history and data rate
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mclk_d_ff <= 1'b0;
         rst_d_ff <= 1'b0;
         rate_ff <= powerup_seq_pkg::RATE_RST;
      end else begin
         mclk_d_ff <= mclk_s;
         rst_d_ff <= rstpin_n_s;
         if (rst_held) begin
            rate_ff <= powerup_seq_pkg::RATE_RST;
         end else if (i_rate_write) begin
            rate_ff <= i_rate;
         end
      end
   end

   // Internal oscillator start-up wait
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !supply_s) begin
         osc_cnt_ff <= '0;
         osc_ff <= 1'b0;
      end else if (osc_cnt_ff < OSC_CYCLES) begin
         osc_cnt_ff <= osc_cnt_ff + 32'h1;
      end else begin
         osc_ff <= 1'b1;
      end
   end

   // Valid-data wait from reset release
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || state_ff == S_RESET) begin
         stable_cnt_ff <= '0;
         stable_ff <= 1'b0;
      end else begin
         if (!stable_done) begin
            stable_cnt_ff <= stable_cnt_ff + 32'h1;
         end
         stable_ff <= stable_done;
      end
   end

   // Power budget watch
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !supply_s) begin
         pwr_cnt_ff <= '0;
         late_ff <= 1'b0;
      end else begin
         if (pwr_cnt_ff < POWERUP_CYCLES) begin
            pwr_cnt_ff <= pwr_cnt_ff + 32'h1;
         end else if (!valid_ff) begin
            late_ff <= 1'b1;
         end
      end
   end

   // Result flags and data-ready pulse
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         data_ready_n_n_ff <= 1'b1;
         settled_ff <= 1'b0;
         valid_ff <= 1'b0;
         run_ff <= 1'b0;
      end else begin
         run_ff <= (nxt_state != S_RESET);
         data_ready_n_n_ff <= ~result_evt;
         if (rst_held) begin
            settled_ff <= 1'b0;
            valid_ff <= 1'b0;
         end else if (restart) begin
            settled_ff <= 1'b0;
         end else if (result_evt) begin
            settled_ff <= 1'b1;
            if (stable_ff) begin
               valid_ff <= 1'b1;
            end
         end
      end
   end

   assign o_osc_running = osc_ff;
   assign o_filter_run = run_ff;
   assign o_data_ready_n = data_ready_n_n_ff;
   assign o_settled = settled_ff;
   assign o_valid = valid_ff;
   assign o_powerup_late = late_ff;
endmodule

//--- verification/powerup_seq_assertions.sv
// Purpose: Port checks for the power-up sequencer
// Assumes: Bound to every sequencer instance
// Notes: Helper counters count i_clk cycles
module powerup_seq_checker #(
   parameter int unsigned STABLE_CYCLES = 200,
   parameter int unsigned OSC_CYCLES = 20
) (
   input wire logic i_clk, // Clock
   input wire logic i_rst_n, // Reset
   input wire logic i_supply_good, // Supply
   input wire logic i_reset_pin_n, // Pin
   input wire logic o_osc_running, // Osc
   input wire logic o_filter_run, // Run
   input wire logic o_data_ready_n, // Ready
   input wire logic o_settled, // Settled
   input wire logic o_valid, // Valid
   input wire logic o_powerup_late // Late
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned run_ff;
   int unsigned sup_ff;
   // Cycles since filter release and since the supply came good
   always_ff @(posedge i_clk) begin
      run_ff <= (!i_rst_n || !o_filter_run) ? 0 : run_ff + 1;
      sup_ff <= (!i_rst_n || !i_supply_good) ? 0 : sup_ff + 1;
   end
   default clocking dcb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   rst_out_a:
      assert property (disable iff (1'b0) !i_rst_n |=> o_data_ready_n && !o_filter_run
         && !o_settled && !o_valid) else $error("outputs not cleared by reset");
   pin_hold_a:
      assert property ((!i_reset_pin_n)[*6] |-> !o_filter_run && !o_settled && !o_valid)
         else $error("running while reset pin low");
   pulse_one_a:
      assert property (!o_data_ready_n |=> o_data_ready_n) else $error("ready low too long");
   settle_mark_a:
      assert property ($rose(o_settled) |-> !o_data_ready_n) else $error("settled off result");
   valid_mark_a:
      assert property ($rose(o_valid) |-> !o_data_ready_n) else $error("valid off result");
   valid_time_a:
      assert property ($rose(o_valid) |-> run_ff >= STABLE_CYCLES - 2) else $error("valid early");
   osc_time_a:
      assert property ($rose(o_osc_running) |-> sup_ff >= OSC_CYCLES) else $error("osc early");
   late_flag_a:
      assert property ($rose(o_powerup_late) |-> !o_valid) else $error("late while valid");
   cover property ($rose(o_valid));
   cover property ($fell(o_settled));
   cover property ($fell(o_filter_run));
   cover property ($rose(o_powerup_late));
endmodule

bind adc_powerup_reset_sequencer powerup_seq_checker #(.STABLE_CYCLES(STABLE_CYCLES),
   .OSC_CYCLES(OSC_CYCLES)) i_powerup_seq_checker (.i_clk, .i_rst_n, .i_supply_good,
   .i_reset_pin_n, .o_osc_running, .o_filter_run, .o_data_ready_n, .o_settled, .o_valid,
   .o_powerup_late);

//--- verification/host_model.sv
// Purpose: Host driving supply, master clock and reset pin
// Assumes: i_go high applies power, low removes it
// Notes: Master clock period is 6 i_clk, still until started
module host_model (
   input wire logic i_clk, // Clock
   input wire logic i_go, // Power request
   output logic o_supply_good, // Supply good
   output logic o_master_clk, // Master clock
   output logic o_reset_pin_n // Reset pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run = 1'b0;
   logic [2:0] cnt_ff = 3'h0;
   // Phase counter; the clock is low whenever it is stopped
   always @(posedge i_clk) cnt_ff <= (!run || cnt_ff == 3'h5) ? 3'h0 : cnt_ff + 3'h1;
   assign o_master_clk = run && (cnt_ff >= 3'h3);
   // Power sequence, repeated for each power request
   initial begin
      o_supply_good = 1'b0;
      o_reset_pin_n = 1'b0;
      forever begin
         wait (i_go);
         @(posedge i_clk) #1 o_supply_good = 1'b1;
         repeat (2500) @(posedge i_clk);
         #1 run = 1'b1;
         repeat (18) @(posedge i_clk);
         #1 o_reset_pin_n = 1'b1;
         wait (!i_go);
         #1 {o_supply_good, o_reset_pin_n, run} = 3'h0;
      end
   end
endmodule

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the power-up sequencer
// Assumes: Host model gives power, master clock and reset pin
// Notes: Counts are master-clock rises seen at the pin; the internal-oscillator test counts i_clk cycles
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic go = 1'b0;
   logic busy = 1'b0;
   logic done = 1'b0;
   logic rate_wr = 1'b0;
   logic [2:0] rate = 3'h4;
   logic int_osc = 1'b0;
   // Shortened start-up and budget counts for the bench
   localparam int OSC_T = 20;
   localparam int POW_T = 20000;
   logic sup, mclk, rpin_n, osc, run, data_ready_n_n, settled, valid, late;
   int bad_count = 0;
   int checks = 0;
   int n;
   always #10 i_clk = !i_clk;
   host_model i_host_model (.i_clk, .i_go(go), .o_supply_good(sup), .o_master_clk(mclk),
      .o_reset_pin_n(rpin_n));
   adc_powerup_reset_sequencer #(.STABLE_CYCLES(200), .OSC_CYCLES(OSC_T), .POWERUP_CYCLES(POW_T))
      i_adc_powerup_reset_sequencer (.i_clk, .i_rst_n, .i_supply_good(sup),
      .i_use_int_osc(int_osc), .i_master_clk(mclk), .i_reset_pin_n(rpin_n),
      .i_reg_write_busy(busy), .i_reg_write_done(done), .i_rate_write(rate_wr),
      .i_rate(rate), .o_osc_running(osc), .o_filter_run(run), .o_data_ready_n(data_ready_n_n),
      .o_settled(settled), .o_valid(valid), .o_powerup_late(late));
   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      if (bad_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Counts master rises until settled (or a result) shows, bounded
   task automatic count_to(input bit on_settled, output int cnt);
      logic prev;
      prev = mclk;
      cnt = 0;
      for (int i = 0; i < 40000; i++) begin
         @(posedge i_clk);
         #2;
         if (mclk && !prev) cnt++;
         prev = mclk;
         if (on_settled ? (settled === 1'b1) : (data_ready_n_n === 1'b0)) break;
      end
   endtask
   // Power-up to the first and second result
   task automatic t_powerup();
      go = 1'b1;
      wait (rpin_n === 1'b1);
      count_to(1'b0, n);
      compare(n, powerup_seq_pkg::SETTLE_DEFAULT);
      compare({settled, valid, osc, run, late}, 5'h1e);
      count_to(1'b0, n);
      compare(n, 32'h200);
   endtask
   // A write restarts settling, held off while busy stays high
   task automatic t_write();
      @(negedge mclk);
      #1;
      done = 1'b1;
      busy = 1'b1;
      @(posedge i_clk) #1 done = 1'b0;
      repeat (100) @(negedge mclk);
      #1 compare({settled, valid}, 2'h1);
      busy = 1'b0;
      count_to(1'b1, n);
      compare(n, powerup_seq_pkg::SETTLE_DEFAULT);
   endtask
   // A rate change uses that rate's settling count and period
   task automatic t_rate();
      @(negedge mclk);
      #1;
      rate = 3'h0;
      rate_wr = 1'b1;
      @(posedge i_clk) #1 rate_wr = 1'b0;
      count_to(1'b1, n);
      compare(n, 32'h128);
      count_to(1'b0, n);
      compare(n, 32'h20);
   endtask
   // Dropping the reset pin stops the filters and clears status
   task automatic t_off();
      go = 1'b0;
      repeat (8) @(posedge i_clk);
      #1 compare({run, settled, valid, data_ready_n_n}, 4'h1);
   endtask
   // Internal oscillator: start after supply, one count per clock, budget overrun
   task automatic t_intosc();
      int k;
      int_osc = 1'b1;
      busy = 1'b1;
      go = 1'b1;
      wait (sup === 1'b1);
      k = 0;
      while (osc !== 1'b1 && k < 100) begin
         @(posedge i_clk);
         #2 k++;
      end
      // Two synchroniser stages plus the edge that sets the flag
      compare(k, OSC_T + 3);
      repeat (POW_T) @(posedge i_clk);
      #2 compare({late, settled, valid}, 3'h4);
      @(posedge i_clk) #1 busy = 1'b0;
      k = 0;
      while (data_ready_n_n !== 1'b0 && k < 5000) begin
         @(posedge i_clk);
         #2 k++;
      end
      compare(k, powerup_seq_pkg::SETTLE_DEFAULT);
      compare({late, settled, valid}, 3'h7);
   endtask
   // Watchdog for a hung sequence
   initial begin
      repeat (80000) @(posedge i_clk);
      bad_count++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge i_clk);
      #1 i_rst_n = 1'b1;
      t_powerup();
      t_write();
      t_rate();
      t_off();
      t_intosc();
      final_report();
   end
endmodule
